// ### rtl/eirqc_params.svh
// eirqc_params.svh: offsets, bit positions and reset values of the external
// interrupt control block. assumes an 8-bit register port with byte offsets.
`ifndef EIRQC_PARAMS_SVH
`define EIRQC_PARAMS_SVH

// register offsets
`define EIRQC_ADDR_W           16
`define EIRQC_OFS_OPTION       16'h1FF1
`define EIRQC_OFS_STATUS_CTRL  16'h000D
`define EIRQC_OFS_EVT_STATUS   16'h0010
`define EIRQC_OFS_EVT_MASK     16'h0011

// option register fields
`define EIRQC_OPT_LEVEL_BIT    1
`define EIRQC_OPT_PORT_BIT     2
`define EIRQC_OPT_RESET        8'h00

// status/control register fields
`define EIRQC_SC_ENABLE_BIT    3
`define EIRQC_SC_PENDING_BIT   2
`define EIRQC_SC_CLEAR_BIT     1

// event status register fields
`define EIRQC_EV_PIN_BIT       0
`define EIRQC_EV_PORT_BIT      1
`define EIRQC_EV_FETCH_BIT     2
`define EIRQC_EV_MASK_RESET    8'h00

`endif

// ### rtl/eirqc_pkg.sv
// eirqc_pkg: types shared by the external interrupt control files.
// assumes the params header is included where constants are needed.
package eirqc_pkg;
  // sensitivity selected by the option register
  typedef enum logic
  {
    EIRQC_EDGE_ONLY,
    EIRQC_EDGE_LEVEL
  } eirqc_sense_t;

  typedef logic [7:0] eirqc_byte_t;
endpackage

// ### rtl/eirqc_detect.sv
// eirqc_detect: falling-edge or edge-plus-low-level detector for one line.
// assumes the input is already synchronous to i_clk.
`timescale 1ns/1ps
module eirqc_detect
  import eirqc_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_line,   // active-low request line
  input  wire eirqc_pkg::eirqc_sense_t i_sense,
  output logic                       o_event   // one-cycle or level request
);
  logic prev;  // line value last cycle; idles high

  // track previous level for falling-edge detection
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prev <= 1'b1;
    else
      prev <= i_line;
  end

  // level mode keeps requesting while the line stays low
  always_comb
  begin
    if (i_sense == EIRQC_EDGE_LEVEL)
      o_event = !i_line;
    else
      o_event = prev && !i_line;
  end
endmodule // eirqc_detect

// ### rtl/eirqc_regs_rd.sv
// eirqc_regs_rd: read multiplexer for the register port.
// assumes the caller registers the result so read data lands one cycle later.
`timescale 1ns/1ps
`include "eirqc_params.svh"
module eirqc_regs_rd
  import eirqc_pkg::*;
(
  input  wire logic [`EIRQC_ADDR_W-1:0] i_addr,
  input  wire eirqc_pkg::eirqc_byte_t   i_option,
  input  wire eirqc_pkg::eirqc_byte_t   i_status_ctrl,
  input  wire eirqc_pkg::eirqc_byte_t   i_evt_status,
  input  wire eirqc_pkg::eirqc_byte_t   i_evt_mask,
  output eirqc_pkg::eirqc_byte_t        o_data
);
  // unmapped offsets read as zero
  always_comb
  begin
    unique case (i_addr)
      `EIRQC_OFS_OPTION:      o_data = i_option;
      `EIRQC_OFS_STATUS_CTRL: o_data = i_status_ctrl;
      `EIRQC_OFS_EVT_STATUS:  o_data = i_evt_status;
      `EIRQC_OFS_EVT_MASK:    o_data = i_evt_mask;
      default:                o_data = 8'h00;
    endcase
  end
endmodule // eirqc_regs_rd

// ### rtl/eirqc_top.sv
// eirqc_top: external interrupt request logic with its register port.
// assumes request pins synchronous to i_clk and a single-cycle strobe master.
// Function
// R1: option bit 1 picks edge or edge+level
// R2: enable bit read/write, set by reset
// R3: pending flag read-only, reset clears it
// R4: pin or enabled port pins set pending
// R5: vector fetch clears pending flag
// R6: writing 1 to clear bit clears pending
// R7: clear bit reads zero, holds no state
// R8: enable gates only external requests
// R9: request out while pending and enabled
`timescale 1ns/1ps
`include "eirqc_params.svh"
module eirqc_top
  import eirqc_pkg::*;
#(
  parameter int PORT_PINS = 4  // port pins that can raise requests
)
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_irq_pin,       // dedicated pin, active low
  input  wire logic [PORT_PINS-1:0]    i_port_a_low_pins,
  input  wire logic                    i_vector_fetch,  // cpu fetches the vector
  input  wire eirqc_pkg::eirqc_byte_t  i_option_strap,  // programmed option value
  input  wire logic [`EIRQC_ADDR_W-1:0] i_addr,
  input  wire eirqc_pkg::eirqc_byte_t  i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output eirqc_pkg::eirqc_byte_t       o_rdata,
  output logic                         o_ext_irq_req,   // to cpu core
  output logic                         o_irq            // event interrupt
);
  import eirqc_pkg::*;

  // elaboration check: the logic serves exactly four port pins
  if (PORT_PINS != 4)
  begin : g_bad_pins
    $error("eirqc_top: PORT_PINS must be 4");
  end

  eirqc_byte_t  mask_option_config;   // programmed options, read-only
  logic         ext_irq_enable;       // software enable
  logic         ext_irq_pending;      // latched request
  eirqc_byte_t  evt_status;           // sticky event bits
  eirqc_byte_t  evt_mask;             // event interrupt mask
  eirqc_sense_t sense;                // current sensitivity
  logic         port_pin_irq_select;  // port pins act as sources
  logic         pin_evt;              // qualifying event on dedicated pin
  logic [PORT_PINS-1:0] port_evt;     // qualifying events on port pins
  logic         port_any;             // enabled port event
  logic         set_pending;          // any source this cycle
  logic         clr_write;            // software clear strobe
  logic         wr_sc;                // write to status/control
  logic         rd_ev;                // read of event status
  logic         opt_loaded;           // option captured after reset
  eirqc_byte_t  rd_mux;               // combinational read value
  eirqc_byte_t  sc_view;              // status/control as read

  // decode of a register hit, shared by read and write paths
  function automatic logic hit(input logic [`EIRQC_ADDR_W-1:0] a,
                               input logic [`EIRQC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // strobe decodes; the clear bit acts only as a strobe and is never stored
  assign wr_sc     = i_wr && hit(i_addr, `EIRQC_OFS_STATUS_CTRL);
  assign rd_ev     = i_rd && hit(i_addr, `EIRQC_OFS_EVT_STATUS);
  assign clr_write = wr_sc && i_wdata[`EIRQC_SC_CLEAR_BIT]; // R6
  assign sense     = mask_option_config[`EIRQC_OPT_LEVEL_BIT] ? // R1
                     EIRQC_EDGE_LEVEL : EIRQC_EDGE_ONLY;
  assign port_pin_irq_select = mask_option_config[`EIRQC_OPT_PORT_BIT];

  // option value is a strap: caught by a clock edge after reset release
  // limitation: the strap is read once, so a new value needs a reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mask_option_config <= `EIRQC_OPT_RESET;
      opt_loaded         <= 1'b0;
    end
    else if (!opt_loaded)
    begin
      mask_option_config <= i_option_strap;
      opt_loaded         <= 1'b1;
    end
  end

  // detector on the dedicated pin
  eirqc_detect u_pin_det
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_line  (i_irq_pin),
    .i_sense (sense),
    .o_event (pin_evt)
  );

  // one detector per port pin
  for (genvar g = 0; g < PORT_PINS; g++)
  begin : g_port
    eirqc_detect u_port_det
    (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_line  (i_port_a_low_pins[g]),
      .i_sense (sense),
      .o_event (port_evt[g])
    );
  end

  // port pins only count when the option selects them
  assign port_any    = port_pin_irq_select && (|port_evt); // R4
  assign set_pending = pin_evt || port_any;                // R4

  // software enable; reset sets it so external requests work at once
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ext_irq_enable <= 1'b1;                               // R2
    else if (wr_sc)
      ext_irq_enable <= i_wdata[`EIRQC_SC_ENABLE_BIT];      // R2
  end

  // pending flag: a new event wins over a clear in the same cycle,
  // so a request landing during the vector fetch is not lost
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ext_irq_pending <= 1'b0;                              // R3
    else if (set_pending)
      ext_irq_pending <= 1'b1;                              // R4
    else if (i_vector_fetch || clr_write)
      ext_irq_pending <= 1'b0;                              // R5 R6
  end

  // request to cpu; the cpu's own mask bit is applied in the core, not here
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ext_irq_req <= 1'b0;
    else
      o_ext_irq_req <= next_req();                          // R9 R8
  end

  function automatic logic next_req();
    next_req = ext_irq_pending && ext_irq_enable;
  endfunction

  // sticky event bits, cleared by reading them; set wins over the read
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      evt_status <= 8'h00;
    else
    begin
      // walk the bits so each source owns one sticky position
      for (int b = 0; b < 8; b++)
      begin
        if (b == `EIRQC_EV_PIN_BIT && pin_evt)
          evt_status[b] <= 1'b1;
        else if (b == `EIRQC_EV_PORT_BIT && port_any)
          evt_status[b] <= 1'b1;
        else if (b == `EIRQC_EV_FETCH_BIT && i_vector_fetch)
          evt_status[b] <= 1'b1;
        else if (rd_ev)
          evt_status[b] <= 1'b0;
      end
    end
  end

  // event mask register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      evt_mask <= `EIRQC_EV_MASK_RESET;
    else if (i_wr && hit(i_addr, `EIRQC_OFS_EVT_MASK))
      evt_mask <= i_wdata;
  end

  // level interrupt from unmasked sticky events
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(evt_status & evt_mask);
  end

  // clear bit never stored: reads zero; option register ignores writes
  always_comb
  begin
    sc_view = 8'h00;                                        // R7
    sc_view[`EIRQC_SC_ENABLE_BIT]  = ext_irq_enable;
    sc_view[`EIRQC_SC_PENDING_BIT] = ext_irq_pending;       // R3
  end

  eirqc_regs_rd u_rd
  (
    .i_addr        (i_addr),
    .i_option      (mask_option_config),
    .i_status_ctrl (sc_view),
    .i_evt_status  (evt_status),
    .i_evt_mask    (evt_mask),
    .o_data        (rd_mux)
  );

  // read data stands only in the cycle after the strobe
  // zero outside the read cycle keeps a shared read bus quiet
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 8'h00;
  end

  // checks watch internal state, so they live beside the logic
  // request follows pending and enable one cycle later
  property p_req_follows;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ext_irq_pending && ext_irq_enable) |=> o_ext_irq_req;
  endproperty
  a_req_follows: assert property (p_req_follows) // R9
    else $error("request missing while pending and enabled");

  // a cleared enable holds the request back
  property p_no_req_disabled;
    @(posedge i_clk) disable iff (!i_rst_n)
      !ext_irq_enable |=> !o_ext_irq_req;
  endproperty
  a_no_req_disabled: assert property (p_no_req_disabled) // R8
    else $error("request while enable clear");

  // a qualifying pin event sets the flag at the next edge
  property p_pin_sets;
    @(posedge i_clk) disable iff (!i_rst_n)
      pin_evt |=> ext_irq_pending;
  endproperty
  a_pin_sets: assert property (p_pin_sets) // R4
    else $error("pin event did not set pending");

  // with port sources off only the pin can raise the flag
  property p_port_gated;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!pin_evt && !port_pin_irq_select && !ext_irq_pending) |=> !ext_irq_pending;
  endproperty
  a_port_gated: assert property (p_port_gated) // R4
    else $error("pending set without enabled source");

  // a vector fetch clears the flag unless a new event lands
  property p_fetch_clears;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_vector_fetch && !set_pending) |=> !ext_irq_pending;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears) // R5
    else $error("vector fetch did not clear pending");

  // writing the clear bit clears the flag unless a new event lands
  property p_write_clears;
    @(posedge i_clk) disable iff (!i_rst_n)
      (clr_write && !set_pending) |=> !ext_irq_pending;
  endproperty
  a_write_clears: assert property (p_write_clears) // R6
    else $error("clear write did not clear pending");

  // a plain write with no source and no clear leaves the flag alone
  property p_pending_ro;
    @(posedge i_clk) disable iff (!i_rst_n)
      (wr_sc && !clr_write && !i_vector_fetch && !set_pending) |=>
        $stable(ext_irq_pending);
  endproperty
  a_pending_ro: assert property (p_pending_ro) // R3
    else $error("write changed pending flag");

  // the clear bit always reads back as zero
  property p_clear_reads_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, `EIRQC_OFS_STATUS_CTRL)) |=> !o_rdata[`EIRQC_SC_CLEAR_BIT];
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) // R7
    else $error("clear bit read as one");

  // the enable bit takes the written value
  property p_enable_written;
    @(posedge i_clk) disable iff (!i_rst_n)
      wr_sc |=> (ext_irq_enable == $past(i_wdata[`EIRQC_SC_ENABLE_BIT]));
  endproperty
  a_enable_written: assert property (p_enable_written) // R2
    else $error("enable did not take written value");

  // a held low level keeps setting the flag in level mode
  property p_level_mode;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sense == EIRQC_EDGE_LEVEL && !i_irq_pin) |=> ext_irq_pending;
  endproperty
  a_level_mode: assert property (p_level_mode) // R1
    else $error("low level ignored in level mode");

  // in edge mode a pin already low last cycle raises nothing new
  property p_edge_only;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sense == EIRQC_EDGE_ONLY && $past(i_rst_n) && !$past(i_irq_pin)) |-> !pin_evt;
  endproperty
  a_edge_only: assert property (p_edge_only) // R1
    else $error("edge mode saw a second event on a held pin");

  // an enabled port pin event sets the flag at the next edge
  property p_port_sets;
    @(posedge i_clk) disable iff (!i_rst_n)
      (port_pin_irq_select && (|port_evt)) |=> ext_irq_pending;
  endproperty
  a_port_sets: assert property (p_port_sets) // R4
    else $error("port pin event did not set pending");

  // a status read shows the flag as it stood at the read edge
  property p_pending_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, `EIRQC_OFS_STATUS_CTRL)) |=>
        (o_rdata[`EIRQC_SC_PENDING_BIT] == $past(ext_irq_pending));
  endproperty
  a_pending_read: assert property (p_pending_read) // R3
    else $error("pending flag read back wrong");

  // the enable bit reads back as stored
  property p_enable_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, `EIRQC_OFS_STATUS_CTRL)) |=>
        (o_rdata[`EIRQC_SC_ENABLE_BIT] == $past(ext_irq_enable));
  endproperty
  a_enable_read: assert property (p_enable_read) // R2
    else $error("enable bit read back wrong");

  // reset leaves the enable set and the flag clear
  property p_reset_state;
    @(posedge i_clk) disable iff (!i_rst_n)
      !$past(i_rst_n) |-> (ext_irq_enable && !ext_irq_pending);
  endproperty
  a_reset_state: assert property (p_reset_state) // R2
    else $error("wrong enable or flag after reset");
endmodule // eirqc_top

// ### tb/eirqc_cpu_model.sv
// eirqc_cpu_model: cpu core stand-in that fetches the external vector.
// assumes a request level from the block and a mask bit from the bench.
`timescale 1ns/1ps
module eirqc_cpu_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_req,    // external request level
  input  wire logic       i_mask,   // condition-code mask, set blocks fetch
  input  wire logic [3:0] i_delay,  // wait cycles before the fetch
  output logic            o_fetch   // one-cycle vector fetch pulse
);
  logic [3:0] cnt;  // cycles an unmasked request has waited
  // fetch once the wait matches; the 4-bit count wraps, so a request held 16 more cycles fetches again
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt     <= 4'h0;
      o_fetch <= 1'b0;
    end
    else
    begin
      o_fetch <= i_req && !i_mask && (cnt == i_delay);
      cnt     <= (i_req && !i_mask) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // eirqc_cpu_model

// ### tb/external_irq_control_bench.sv
// external_irq_control_bench: self-checking bench of the interrupt block.
// assumes the cpu model is compiled before this file.
`timescale 1ns/1ps
`include "eirqc_params.svh"
module external_irq_control_bench;
  import eirqc_pkg::*;
  logic        i_clk    = 1'b0;   // 200 MHz clock
  logic        i_rst_n  = 1'b0;   // async reset
  logic        pin      = 1'b1;   // dedicated pin, idle high
  logic [3:0]  port     = 4'hF;   // port pins, idle high
  eirqc_byte_t strap    = 8'h00;  // programmed option value
  logic [15:0] addr     = 16'h0000;
  eirqc_byte_t wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        cpu_mask = 1'b1;   // set keeps the cpu from fetching
  logic [3:0]  delay    = 4'h0;   // cpu fetch latency
  eirqc_byte_t rdata;             // read data
  logic        req;               // request to the cpu
  logic        irq;               // event interrupt
  logic        fetch;             // vector fetch
  int          err_total   = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'h37CC;   // xorshift state
  eirqc_byte_t d;                 // last read value
  // free-running clock
  always #2.5 i_clk = ~i_clk;
  eirqc_top #(.PORT_PINS(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq_pin(pin),
    .i_port_a_low_pins(port), .i_vector_fetch(fetch), .i_option_strap(strap),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_ext_irq_req(req), .o_irq(irq));
  eirqc_cpu_model cpu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_mask(cpu_mask), .i_delay(delay), .o_fetch(fetch));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected status/control read: clear bit always reads zero
  function automatic eirqc_byte_t sc(input logic en, input logic pend);
    return (eirqc_byte_t'(en) << `EIRQC_SC_ENABLE_BIT) |
           (eirqc_byte_t'(pend) << `EIRQC_SC_PENDING_BIT);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic bus_wr(input logic [15:0] a, input eirqc_byte_t v);
    @(posedge i_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge i_clk);
    wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a);
    @(posedge i_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd   <= 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask
  task automatic chk(input eirqc_byte_t got, input eirqc_byte_t exp);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic do_reset(input eirqc_byte_t s);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    strap   <= s;
    cyc(10);
    i_rst_n <= 1'b1;
    cyc(3);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    do_reset(8'h00);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b0));
    chk({7'h00, irq}, 8'h00);
    @(posedge i_clk);
    pin <= 1'b0;
    cyc(3);
    chk({7'h00, req}, 8'h01);
    bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h0C);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b1));
    bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h0A);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b0));
    chk(d, sc(1'b1, 1'b0));
    @(posedge i_clk);
    pin <= 1'b1;
    chk({7'h00, irq}, 8'h00);
    bus_wr(`EIRQC_OFS_EVT_MASK, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    bus_rd(`EIRQC_OFS_EVT_STATUS);
    chk(d, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    repeat (4)
    begin
      seed = xs(seed);
      bus_wr(`EIRQC_OFS_EVT_MASK, seed[7:0]);
      bus_rd(`EIRQC_OFS_EVT_MASK);
      chk(d, seed[7:0]);
    end
    bus_rd(16'h0100);
    chk(d, 8'h00);
    bus_wr(`EIRQC_OFS_OPTION, 8'hFF);
    bus_rd(`EIRQC_OFS_OPTION);
    chk(d, 8'h00);
    // enable off: flag sets, request held back
    bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h00);
    pin <= 1'b0;
    cyc(3);
    chk({7'h00, req}, 8'h00);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b0, 1'b1));
    bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h08);
    pin   <= 1'b1;
    delay <= seed[3:0];
    cyc(2);
    chk({7'h00, req}, 8'h01);
    cpu_mask <= 1'b0;
    repeat (40)
    begin
      @(posedge i_clk);
      if (fetch === 1'b1)
        break;
    end
    cyc(3);
    cpu_mask <= 1'b1;
    chk({7'h00, req}, 8'h00);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b0));
    bus_rd(`EIRQC_OFS_EVT_STATUS);
    chk(d, 8'h05);
    // level mode, port sources off
    do_reset(8'h02);
    port <= 4'h0;
    cyc(3);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b0));
    @(posedge i_clk);
    port <= 4'hF;
    pin  <= 1'b0;
    cyc(3);
    bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h0A);
    bus_rd(`EIRQC_OFS_STATUS_CTRL);
    chk(d, sc(1'b1, 1'b1));
    @(posedge i_clk);
    pin <= 1'b1;
    // edge mode with each port pin as a source
    do_reset(8'h04);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_clk);
      port[i] <= 1'b0;
      cyc(3);
      bus_rd(`EIRQC_OFS_STATUS_CTRL);
      chk(d, sc(1'b1, 1'b1));
      bus_rd(`EIRQC_OFS_EVT_STATUS);
      chk(d, 8'h02);
      @(posedge i_clk);
      port[i] <= 1'b1;
      bus_wr(`EIRQC_OFS_STATUS_CTRL, 8'h0A);
      bus_rd(`EIRQC_OFS_STATUS_CTRL);
      chk(d, sc(1'b1, 1'b0));
    end
    give_verdict();
  end
endmodule // external_irq_control_bench
